// File: logic/usb_host_cmd_status_irq_regs.vh
// Register map and field constants for the host command/status and event block
// Overview of operation
// - Software sets reset request; controller clears it
// - Control list pending: software and controller write
// - Bulk list pending: software and controller write
// - Two-bit overrun counter, increments, wraps, read-only
// - Set overrun flag on frame schedule overrun
// - Set done-head flag after head writeback
// - Set frame start flag every frame
// - Resume flag from bus, not software resume
// - Set fatal flag on non-bus system error
// - Set wrap flag when frame bit 15 toggles
// - Set hub flag on any hub status change
// - Ownership request sets flag; enabled raises SMI
// - Write one clears a flag, zero ignored
// - Enable bit lets its flag interrupt; zero ignored
// - Master enable gates all interrupt generation
// - Route bit picks system management or normal output for the seven low events; ownership always goes to SMI
// - Disable register clears enables on written ones
`ifndef USB_HOST_CMD_STATUS_IRQ_REGS_VH
`define USB_HOST_CMD_STATUS_IRQ_REGS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ADDR_W               8
`define OFF_CONTROL          8'h04
`define OFF_COMMAND_STATUS   8'h08
`define OFF_EVENT_STATUS     8'h0C
`define OFF_ENABLE_SET       8'h10
`define OFF_ENABLE_CLEAR     8'h14

// ----------------------------------------------------------------------------
// Command/status fields
// ----------------------------------------------------------------------------
`define CMD_SOFT_RESET       0
`define CMD_CTRL_PENDING     1
`define CMD_BULK_PENDING     2
`define CMD_OWNER_REQ        3
`define CMD_OVR_CNT_LO       16
`define CMD_OVR_CNT_HI       17
`define OVR_CNT_W            2
`define OVR_CNT_RESET        2'h0
`define OVR_CNT_STEP         2'h1

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define CTL_ROUTE            8

// ----------------------------------------------------------------------------
// Event status and enable fields
// ----------------------------------------------------------------------------
`define EV_NUM               8
`define EV_OVERRUN           0
`define EV_DONE_HEAD         1
`define EV_FRAME_START       2
`define EV_RESUME            3
`define EV_FATAL             4
`define EV_FRAME_WRAP        5
`define EV_HUB_CHANGE        6
`define EV_OWNER             7
`define EV_LOW_NUM           7
`define BIT_OWNER            30
`define BIT_MASTER           31
`define FRAME_NUM_W          16
`define FRAME_MSB            15

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_WORD             32'h00000000
`define RST_FLAGS            8'h00
`define RST_BIT              1'b0

`endif

// File: logic/event_flag_bank.v
// Bank of sticky event flags, set by hardware, cleared by writing one
`include "usb_host_cmd_status_irq_regs.vh"
`default_nettype none

module event_flag_bank #(
  parameter NUM = 8
) (
  // Clock and reset
  input  wire           ref_clk,
  input  wire           sys_rst,
  // Hardware event pulses
  input  wire [NUM-1:0] setPulse,
  // Software clear mask
  input  wire           clrEn,
  input  wire [NUM-1:0] clrMask,
  // Flag state
  output wire [NUM-1:0] flags
);

  genvar i;
  generate
    for (i = 0; i < NUM; i = i + 1) begin : gFlag
      reg flagBit_q;

      always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          flagBit_q <= `RST_BIT;
        end else if (setPulse[i]) begin
          // Set beats a clear in the same cycle
          flagBit_q <= 1'b1;
        end else if (clrEn && clrMask[i]) begin
          flagBit_q <= 1'b0;
        end
      end

      assign flags[i] = flagBit_q;
    end
  endgenerate

endmodule

`default_nettype wire

// File: logic/usb_host_cmd_status_irq.v
// Command/status word, event flags and interrupt enables of a USB host controller
`include "usb_host_cmd_status_irq_regs.vh"
`default_nettype none

module usb_host_cmd_status_irq (
  // Clock and reset
  input  wire                    ref_clk,
  input  wire                    sys_rst,
  // Register port
  input  wire [`ADDR_W-1:0]      regAddr,
  input  wire [31:0]             regWrData,
  input  wire                    regWrEn,
  input  wire                    regRdEn,
  output reg  [31:0]             regRdData,
  // Controller engine events
  input  wire                    schedOverrun,
  input  wire                    doneHeadWritten,
  input  wire                    frameStart,
  input  wire                    resumeSignal,
  input  wire                    resumeState,
  input  wire                    fatalSystemError,
  input  wire [`FRAME_NUM_W-1:0] frameNumber,
  input  wire                    hubStatusChange,
  // Controller side of the command word
  input  wire                    softResetDone,
  input  wire                    ctrlListClear,
  input  wire                    bulkListClear,
  input  wire                    ownerChangeDone,
  output wire                    softResetRequest,
  output wire                    controlListPending,
  output wire                    bulkListPending,
  output wire                    ownershipChangeRequest,
  output wire                    irqRouteSelect,
  // Interrupt outputs
  output reg                     systemMgmtIrqOut,
  output reg                     normalIrqOut
);

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  wire wrControl = regWrEn && hit(regAddr, `OFF_CONTROL);
  wire wrCommand = regWrEn && hit(regAddr, `OFF_COMMAND_STATUS);
  wire wrStatus  = regWrEn && hit(regAddr, `OFF_EVENT_STATUS);
  wire wrEnSet   = regWrEn && hit(regAddr, `OFF_ENABLE_SET);
  wire wrEnClr   = regWrEn && hit(regAddr, `OFF_ENABLE_CLEAR);

  // --------------------------------------------------------------------------
  // Control word: routing bit
  // --------------------------------------------------------------------------
  reg routeSel_q;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      routeSel_q <= `RST_BIT;
    end else if (wrControl) begin
      routeSel_q <= regWrData[`CTL_ROUTE];
    end
  end

  assign irqRouteSelect = routeSel_q;

  // --------------------------------------------------------------------------
  // Command word
  // --------------------------------------------------------------------------
  reg                  softReset_q;
  reg                  ctrlPending_q;
  reg                  bulkPending_q;
  reg                  ownerReq_q;
  reg [`OVR_CNT_W-1:0] ovrCount_q;

  wire ownerReqWrite = wrCommand && regWrData[`CMD_OWNER_REQ];

  // Software sets, controller clears once its reset is done
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      softReset_q <= `RST_BIT;
    end else if (wrCommand && regWrData[`CMD_SOFT_RESET]) begin
      softReset_q <= 1'b1;
    end else if (softResetDone) begin
      softReset_q <= 1'b0;
    end
  end

  // Software write has priority over controller clear
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlPending_q <= `RST_BIT;
    end else if (wrCommand) begin
      ctrlPending_q <= regWrData[`CMD_CTRL_PENDING];
    end else if (ctrlListClear) begin
      ctrlPending_q <= 1'b0;
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bulkPending_q <= `RST_BIT;
    end else if (wrCommand) begin
      bulkPending_q <= regWrData[`CMD_BULK_PENDING];
    end else if (bulkListClear) begin
      bulkPending_q <= 1'b0;
    end
  end

  // Request held until the controller reports the hand-over
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ownerReq_q <= `RST_BIT;
    end else if (ownerReqWrite) begin
      ownerReq_q <= 1'b1;
    end else if (ownerChangeDone) begin
      ownerReq_q <= 1'b0;
    end
  end

  // Overrun counter wraps naturally at its width
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovrCount_q <= `OVR_CNT_RESET;
    end else if (schedOverrun) begin
      ovrCount_q <= ovrCount_q + `OVR_CNT_STEP;
    end
  end

  assign softResetRequest       = softReset_q;
  assign controlListPending     = ctrlPending_q;
  assign bulkListPending        = bulkPending_q;
  assign ownershipChangeRequest = ownerReq_q;

  // --------------------------------------------------------------------------
  // Frame number wrap detection
  // --------------------------------------------------------------------------
  reg frameMsb_q;
  reg frameSeen_q;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frameMsb_q <= `RST_BIT;
    end else begin
      frameMsb_q <= frameNumber[`FRAME_MSB];
    end
  end

  // First sample after reset only primes the history
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frameSeen_q <= `RST_BIT;
    end else begin
      frameSeen_q <= 1'b1;
    end
  end

  wire frameWrap = frameSeen_q && (frameNumber[`FRAME_MSB] != frameMsb_q);

  // --------------------------------------------------------------------------
  // Event flags
  // --------------------------------------------------------------------------
  wire [`EV_NUM-1:0] evSet;
  wire [`EV_NUM-1:0] evClrMask;
  wire [`EV_NUM-1:0] evFlags;

  assign evSet[`EV_OVERRUN]     = schedOverrun;
  assign evSet[`EV_DONE_HEAD]   = doneHeadWritten;
  assign evSet[`EV_FRAME_START] = frameStart;
  // Software-entered resume is not a detected resume
  assign evSet[`EV_RESUME]      = resumeSignal && !resumeState;
  assign evSet[`EV_FATAL]       = fatalSystemError;
  assign evSet[`EV_FRAME_WRAP]  = frameWrap;
  assign evSet[`EV_HUB_CHANGE]  = hubStatusChange;
  assign evSet[`EV_OWNER]       = ownerReqWrite;

  // Clearing done-head before saving the head is up to software
  assign evClrMask = {regWrData[`BIT_OWNER],
                      regWrData[`EV_LOW_NUM-1:0]};

  event_flag_bank #(
    .NUM      (`EV_NUM)
  ) uFlags (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .setPulse (evSet),
    .clrEn    (wrStatus),
    .clrMask  (evClrMask),
    .flags    (evFlags)
  );

  // --------------------------------------------------------------------------
  // Interrupt enables
  // --------------------------------------------------------------------------
  reg [`EV_NUM-1:0] evEnable_q;
  reg               masterEn_q;

  wire [`EV_NUM-1:0] enWrMask = evClrMask;

  // Ones in the set register set, ones in the clear register clear
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      evEnable_q <= `RST_FLAGS;
    end else if (wrEnSet) begin
      evEnable_q <= evEnable_q | enWrMask;
    end else if (wrEnClr) begin
      evEnable_q <= evEnable_q & ~enWrMask;
    end
  end

  // Master enable uses the same set and clear pair
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      masterEn_q <= `RST_BIT;
    end else if (wrEnSet) begin
      masterEn_q <= masterEn_q | regWrData[`BIT_MASTER];
    end else if (wrEnClr) begin
      masterEn_q <= masterEn_q & ~regWrData[`BIT_MASTER];
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt generation
  // --------------------------------------------------------------------------
  wire [`EV_NUM-1:0] evActive = evFlags & evEnable_q;
  wire lowActive   = |evActive[`EV_LOW_NUM-1:0];
  wire ownerActive = evActive[`EV_OWNER];

  // Levels follow the flags and enables, so they drop only when software clears one or changes the route bit
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      systemMgmtIrqOut <= `RST_BIT;
      normalIrqOut     <= `RST_BIT;
    end else begin
      systemMgmtIrqOut <= masterEn_q &&
                          ((lowActive && routeSel_q) || ownerActive);
      normalIrqOut     <= masterEn_q && lowActive && !routeSel_q;
    end
  end

  // --------------------------------------------------------------------------
  // Read-back words
  // --------------------------------------------------------------------------
  reg [31:0] controlWord;
  reg [31:0] commandWord;
  reg [31:0] statusWord;
  reg [31:0] enableWord;

  // Unlisted bits stay zero
  always @* begin
    controlWord = `RST_WORD;
    controlWord[`CTL_ROUTE] = routeSel_q;
  end

  always @* begin
    commandWord = `RST_WORD;
    commandWord[`CMD_SOFT_RESET]   = softReset_q;
    commandWord[`CMD_CTRL_PENDING] = ctrlPending_q;
    commandWord[`CMD_BULK_PENDING] = bulkPending_q;
    commandWord[`CMD_OWNER_REQ]    = ownerReq_q;
    commandWord[`CMD_OVR_CNT_HI:`CMD_OVR_CNT_LO] = ovrCount_q;
  end

  always @* begin
    statusWord = `RST_WORD;
    statusWord[`EV_LOW_NUM-1:0] = evFlags[`EV_LOW_NUM-1:0];
    statusWord[`BIT_OWNER]      = evFlags[`EV_OWNER];
  end

  always @* begin
    enableWord = `RST_WORD;
    enableWord[`EV_LOW_NUM-1:0] = evEnable_q[`EV_LOW_NUM-1:0];
    enableWord[`BIT_OWNER]      = evEnable_q[`EV_OWNER];
    enableWord[`BIT_MASTER]     = masterEn_q;
  end

  // --------------------------------------------------------------------------
  // Read data, one cycle after the strobe
  // --------------------------------------------------------------------------
  reg [31:0] rdMux;

  always @* begin
    case (regAddr)
      `OFF_CONTROL:        rdMux = controlWord;
      `OFF_COMMAND_STATUS: rdMux = commandWord;
      `OFF_EVENT_STATUS:   rdMux = statusWord;
      `OFF_ENABLE_SET:     rdMux = enableWord;
      `OFF_ENABLE_CLEAR:   rdMux = enableWord;
      default:             rdMux = `RST_WORD;
    endcase
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= `RST_WORD;
    end else if (regRdEn) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= `RST_WORD;
    end
  end

endmodule

`default_nettype wire

// File: dv/engine_model.sv
// Controller engine model answering the command word requests
`default_nettype none
module engine_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Answer speed
  input  wire logic       slow,
  // Requests and completion pulses
  input  wire logic [3:0] req,
  output var  logic [3:0] done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_q [4];
  // ----
  // One delay counter per request
  // ----
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    for (int i = 0; i < 4; i++) begin
      if (sys_rst) begin
        cnt_q[i] <= 5'h00;
        done[i]  <= 1'h0;
      end else if (req[i] && !done[i] && cnt_q[i] >= (slow ? 5'h14 : 5'h01)) begin
        cnt_q[i] <= 5'h00;
        done[i]  <= 1'h1;
      end else begin
        cnt_q[i] <= (req[i] && !done[i]) ? cnt_q[i] + 5'h01 : 5'h00;
        done[i]  <= 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/usb_host_cmd_status_irq_assertions.sv
// Port checks on the command/status and interrupt block
`default_nettype none
module usb_host_cmd_status_irq_assertions (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // Register port
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [31:0] regRdData,
  // Command word
  input wire logic        softResetDone,
  input wire logic        bulkListClear,
  input wire logic        softResetRequest,
  input wire logic        controlListPending,
  input wire logic        bulkListPending,
  input wire logic        ownershipChangeRequest,
  input wire logic        irqRouteSelect,
  // Interrupts
  input wire logic        systemMgmtIrqOut,
  input wire logic        normalIrqOut
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic cmdWr;
  assign cmdWr = regWrEn && regAddr == 8'h08;
  // Output stays up while nothing can clear it
  property holdIrq(irq);
    irq && !regWrEn && !$past(regWrEn) && !softResetDone && !$past(softResetDone) |=> irq;
  endproperty
  chk_reset_set: assert property (cmdWr && regWrData[0] |=> softResetRequest)
    else $error("reset request not set");
  chk_reset_clear: assert property (softResetRequest && softResetDone && !cmdWr |=>
    !softResetRequest) else $error("reset request not cleared");
  chk_ctrl_load: assert property (cmdWr |=> controlListPending == $past(regWrData[1]))
    else $error("control pending not loaded");
  chk_bulk_clear: assert property (bulkListClear && !cmdWr |=> !bulkListPending)
    else $error("bulk pending not cleared");
  chk_owner_set: assert property (cmdWr && regWrData[3] |=> ownershipChangeRequest)
    else $error("ownership request not set");
  chk_route_load: assert property (regWrEn && regAddr == 8'h04 |=>
    irqRouteSelect == $past(regWrData[8])) else $error("route bit not loaded");
  chk_route_norm: assert property (normalIrqOut |-> !$past(irqRouteSelect))
    else $error("normal irq while routed away");
  chk_norm_hold: assert property (holdIrq(normalIrqOut))
    else $error("normal irq dropped");
  chk_smi_hold: assert property (holdIrq(systemMgmtIrqOut))
    else $error("smi dropped");
  chk_rd_idle: assert property (!$past(regRdEn) |-> regRdData == 32'h00000000)
    else $error("read data outside read answer");
  cover property (normalIrqOut);
  cover property (systemMgmtIrqOut && irqRouteSelect);
  cover property ($fell(softResetRequest));
endmodule
bind usb_host_cmd_status_irq usb_host_cmd_status_irq_assertions u_chk (
  .ref_clk, .sys_rst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
  .softResetDone, .bulkListClear, .softResetRequest, .controlListPending,
  .bulkListPending, .ownershipChangeRequest, .irqRouteSelect, .systemMgmtIrqOut,
  .normalIrqOut);
`default_nettype wire

// File: dv/usb_host_cmd_status_irq_test.sv
// Self-checking bench for the command/status and interrupt block
`default_nettype none
module usb_host_cmd_status_irq_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk     = 1'h0;
  logic        sys_rst     = 1'h1;
  logic [7:0]  regAddr     = 8'h00;
  logic [31:0] regWrData   = 32'h00000000;
  logic        regWrEn     = 1'h0;
  logic        regRdEn     = 1'h0;
  logic [31:0] regRdData;
  logic [6:0]  ev          = 7'h00;
  logic        resumeState = 1'h0;
  logic [15:0] fn          = 16'h0000;
  logic        slow        = 1'h1;
  logic [3:0]  done;
  logic [3:0]  req;
  logic        route;
  logic        smi;
  logic        nrm;
  int          n_mismatch  = 0;
  int          n_tests     = 0;
  int          flg         = 0;
  int          en          = 0;
  int          cnt         = 0;
  int          rt          = 0;
  always #12.5 ref_clk = ~ref_clk;
  usb_host_cmd_status_irq u_usb_host_cmd_status_irq (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .schedOverrun(ev[0]),
    .doneHeadWritten(ev[1]), .frameStart(ev[2]), .resumeSignal(ev[3]),
    .resumeState(resumeState), .fatalSystemError(ev[4]), .frameNumber(fn),
    .hubStatusChange(ev[6]), .softResetDone(done[0]), .ctrlListClear(done[1]),
    .bulkListClear(done[2]), .ownerChangeDone(done[3]), .softResetRequest(req[0]),
    .controlListPending(req[1]), .bulkListPending(req[2]), .ownershipChangeRequest(req[3]),
    .irqRouteSelect(route), .systemMgmtIrqOut(smi), .normalIrqOut(nrm));
  engine_model u_engine_model (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .slow(slow), .req(req), .done(done));
  // ----
  // Bus tasks with the register model beside them
  // ----
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    regWrEn   <= 1'h1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrEn <= 1'h0;
    if (a == 8'h0C) flg &= ~d;
    if (a == 8'h10) en |= d & 32'hC000007F;
    if (a == 8'h14) en &= ~d;
    if (a == 8'h04) rt = d[8];
    if (a == 8'h08 && d[3]) flg |= 32'h40000000;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regRdEn <= 1'h1;
    regAddr <= a;
    @(posedge ref_clk);
    regRdEn <= 1'h0;
    #1;
    d = regRdData;
  endtask
  task automatic pulse(int i);
    @(posedge ref_clk);
    if (i == 5) fn <= {~fn[15], 15'($urandom)};
    else ev[i] <= 1'h1;
    @(posedge ref_clk);
    ev <= 7'h00;
    if (!(i == 3 && resumeState)) flg |= 1 << i;
    if (i == 0) cnt = (cnt + 1) % 4;
  endtask
  task automatic checkAll();
    logic [31:0] d;
    logic        low;
    rd(8'h0C, d);
    check("status", d, flg);
    rd(8'h10, d);
    check("enable", d, en);
    rd(8'h14, d);
    check("disable view", d, en);
    rd(8'h08, d);
    check("command", d & 32'hFFFFFFF0, cnt << 16);
    low = en[31] && (flg & en & 32'h7F) != 0;
    check("normal irq", nrm, low && !rt);
    check("smi", smi, (low && rt) || (en[31] && flg[30] && en[30]));
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    logic [31:0] d;
    int          k;
    void'($urandom(55604));
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'h0;
    wr(8'h20, 32'hFFFFFFFF);
    for (int j = 0; j < 6; j++) begin
      rd(8'h04 * j + 8'h04, d);
      check("reset read", d, 32'h00000000);
    end
    $display("test reset done");
    @(posedge ref_clk);
    resumeState <= 1'h1;
    pulse(3);
    resumeState <= 1'h0;
    checkAll();
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      checkAll();
      wr(8'h10, 32'h80000000 | (32'h1 << i));
      checkAll();
      wr(8'h10, 32'h00000000);
      wr(8'h0C, 32'h00000000);
      checkAll();
      // Status already read back, so clearing the flag of event i is allowed
      wr(8'h0C, 32'h1 << i);
      checkAll();
      wr(8'h14, $urandom);
      wr(8'h10, $urandom);
      checkAll();
    end
    $display("test events done");
    repeat (5) pulse(0);
    wr(8'h08, 32'h00030000);
    checkAll();
    wr(8'h10, 32'hC000007F);
    wr(8'h04, 32'h00000100);
    checkAll();
    check("route pin", route, 1'h1);
    wr(8'h04, 32'h00000000);
    wr(8'h0C, 32'hFFFFFFFF);
    wr(8'h08, 32'h00000008);
    #1;
    check("owner req", req[3], 1'h1);
    checkAll();
    wr(8'h14, 32'h40000000);
    checkAll();
    $display("test routing done");
    for (int s = 0; s < 2; s++) begin
      slow <= (s == 1);
      wr(8'h08, 32'h00000007);
      #1;
      check("command pins", req[2:0], 3'h7);
      k = 0;
      while (req !== 4'h0 && k < 100) begin
        @(posedge ref_clk);
        #1;
        k++;
      end
      check("controller clear", req, 4'h0);
    end
    $display("test command done");
    summarize();
  end
endmodule
`default_nettype wire
